// file: sois_pkg.sv
// Package: constants for the serial output idle-select block
`default_nettype none
package sois_pkg;
  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CLK   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TXBUF = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_SHIFT = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_PORT  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQST = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQMK = 5'h18;
  // Mode register fields
  localparam int MODE_ENABLE = 7;
  localparam int MODE_TXMODE = 6;
  localparam int MODE_ORDER  = 4;
  localparam int MODE_PHASE  = 3;
  localparam int MODE_BUSY   = 0;
  // Clock select register field
  localparam int CLK_POL = 4;
  // Port register fields
  localparam int PORT_DIR   = 0;
  localparam int PORT_LATCH = 1;
  // Interrupt flag register field
  localparam int IRQ_DONE = 2;
  // Widths and counts
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 4;
  localparam logic [CNT_W-1:0]  BITS_PER_XFER = 4'h8;
  localparam logic [CNT_W-1:0]  CNT_ZERO      = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 4'h1;
  localparam logic [BYTE_W-1:0] BYTE_ZERO     = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO     = 32'h0000_0000;
  localparam logic [BYTE_W-1:0] MODE_RST      = 8'h00;
  localparam logic [BYTE_W-1:0] CLK_RST       = 8'h00;
  localparam logic [1:0]        PORT_RST      = 2'h1;
endpackage
`default_nettype wire

// file: sois_top.sv
// Clocked serial unit with idle-level selection of the serial data output
// Function
// - Unit disabled: serial data output carries an idle value from mode settings.
// - Disabled, transmit mode 0: output low; this is also the reset state.
// - Disabled, transmit mode 1, phase 0: output from latch, which holds low.
// - Disabled, transmit mode 1, phase 1, order 0: output transmit buffer bit 7.
// - Disabled, transmit mode 1, phase 1, order 1: output transmit buffer bit 0.
// - Writing mode, phase or order bits updates the idle output immediately.
// - Pin level depends on port direction and port latch plus serial output.
// - After 8 bits: set transfer done flag, clear in-progress, next may start.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`default_nettype none
module sois_top (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [sois_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [sois_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [sois_pkg::DATA_W-1:0] wb_dat_o,
  output logic                            wb_ack_o,
  // Serial link pins
  input  wire logic                       serial_clk_in,
  input  wire logic                       serial_data_in,
  input  wire logic                       data_pin_i,
  output logic                            data_pin_o,
  output logic                            data_pin_oe,
  // Internal serial data output and interrupt
  output logic                            serial_data_out,
  output logic                            irq
);
  import sois_pkg::*;

  // Register state
  logic [BYTE_W-1:0] mode_ff;
  logic [BYTE_W-1:0] clk_cfg_ff;
  logic [BYTE_W-1:0] transmit_buffer_ff;
  logic [BYTE_W-1:0] shift_ff;
  logic [1:0]        port_ff;
  logic [BYTE_W-1:0] irq_status_ff;
  logic [BYTE_W-1:0] irq_mask_ff;
  logic              busy_ff;
  logic [CNT_W-1:0]  bit_cnt_ff;
  logic              out_latch_ff;
  logic              ack_ff;
  logic [DATA_W-1:0] rdata_ff;
  // Synchronisers and edge history
  logic [1:0]        sck_sync_ff;
  logic [1:0]        sin_sync_ff;
  logic              sck_prev_ff;

  // Field aliases
  logic serial_unit_enable_bit;
  logic transmit_mode_bit;
  logic data_phase_bit;
  logic bit_order_bit;
  logic port_direction_bit;
  logic port_latch_bit;
  assign serial_unit_enable_bit = mode_ff[MODE_ENABLE];
  assign transmit_mode_bit      = mode_ff[MODE_TXMODE];
  assign data_phase_bit         = mode_ff[MODE_PHASE];
  assign bit_order_bit          = mode_ff[MODE_ORDER];
  assign port_direction_bit     = port_ff[PORT_DIR];
  assign port_latch_bit         = port_ff[PORT_LATCH];

  // First bit to leave a byte for the chosen order
  function automatic logic lead_bit(input logic [BYTE_W-1:0] d, input logic order);
    lead_bit = order ? d[0] : d[BYTE_W-1];
  endfunction

  // Bus decode; the access completes on the edge where ack is high
  logic bus_req;
  logic wr_now;
  logic rd_now;
  logic hit;
  logic [BYTE_W-1:0] wbyte;
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_now  = bus_req & ack_ff & wb_we_i;
  assign rd_now  = bus_req & ack_ff & ~wb_we_i;
  assign wbyte   = wb_dat_i[BYTE_W-1:0];
  assign hit     = wb_sel_i[0];

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end
  assign wb_ack_o = ack_ff;

  // Read data captured while ack is pending; unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= WORD_ZERO;
    end else if (bus_req & ~ack_ff) begin
      rdata_ff <= WORD_ZERO;
      unique case (wb_adr_i)
        OFS_MODE:  rdata_ff[BYTE_W-1:0] <= {mode_ff[BYTE_W-1:1], busy_ff};
        OFS_CLK:   rdata_ff[BYTE_W-1:0] <= clk_cfg_ff;
        OFS_TXBUF: rdata_ff[BYTE_W-1:0] <= transmit_buffer_ff;
        OFS_SHIFT: rdata_ff[BYTE_W-1:0] <= shift_ff;
        OFS_PORT:  rdata_ff[1:0]        <= port_ff;
        OFS_IRQST: rdata_ff[BYTE_W-1:0] <= irq_status_ff;
        OFS_IRQMK: rdata_ff[BYTE_W-1:0] <= irq_mask_ff;
        default:   rdata_ff <= WORD_ZERO;
      endcase
    end
  end
  assign wb_dat_o = rdata_ff;

  // Software-written control registers; busy bit is read-only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff     <= MODE_RST;
      clk_cfg_ff  <= CLK_RST;
      port_ff     <= PORT_RST;
      irq_mask_ff <= BYTE_ZERO;
    end else if (wr_now & hit) begin
      if (wb_adr_i == OFS_MODE) begin
        mode_ff <= {wbyte[BYTE_W-1:1], 1'b0};
      end
      if (wb_adr_i == OFS_CLK) begin
        clk_cfg_ff <= wbyte;
      end
      if (wb_adr_i == OFS_PORT) begin
        port_ff <= wbyte[1:0];
      end
      if (wb_adr_i == OFS_IRQMK) begin
        irq_mask_ff <= wbyte;
      end
    end
  end

  // Transmit buffer holds the next byte and feeds the idle selector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmit_buffer_ff <= BYTE_ZERO;
    end else if (wr_now & hit & (wb_adr_i == OFS_TXBUF) & ~busy_ff) begin
      transmit_buffer_ff <= wbyte;
    end
  end

  // Two-stage synchronisers for pin inputs; only the second stage is used
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Start at the reset idle level of the clock so no false edge follows reset
      sck_sync_ff <= {2{~CLK_RST[CLK_POL]}};
      sin_sync_ff <= 2'h0;
      sck_prev_ff <= ~CLK_RST[CLK_POL];
    end else begin
      sck_sync_ff <= {sck_sync_ff[0], serial_clk_in};
      sin_sync_ff <= {sin_sync_ff[0], serial_data_in};
      sck_prev_ff <= sck_sync_ff[1];
    end
  end

  // Edge finding: polarity 0 idles high, so the leading edge is falling
  logic sck_idle;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic drive_edge;
  logic sin_s;
  assign sck_idle    = ~clk_cfg_ff[CLK_POL];
  assign lead_edge   = (sck_prev_ff == sck_idle) & (sck_sync_ff[1] != sck_idle);
  assign trail_edge  = (sck_prev_ff != sck_idle) & (sck_sync_ff[1] == sck_idle);
  assign sample_edge = data_phase_bit ? lead_edge : trail_edge;
  assign drive_edge  = data_phase_bit ? trail_edge : lead_edge;
  assign sin_s       = sin_sync_ff[1];

  // Start: buffer write in transmit mode, or shift register read in receive mode
  logic start;
  logic last_sample;
  logic done_pulse;
  assign start = serial_unit_enable_bit & ~busy_ff &
                 ((wr_now & hit & (wb_adr_i == OFS_TXBUF) & transmit_mode_bit) |
                  (rd_now & (wb_adr_i == OFS_SHIFT) & ~transmit_mode_bit));
  assign last_sample = busy_ff & sample_edge & (bit_cnt_ff == BITS_PER_XFER - CNT_ONE);
  assign done_pulse  = last_sample;

  // In-progress flag and bit counter; disabling aborts the transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff    <= 1'b0;
      bit_cnt_ff <= CNT_ZERO;
    end else if (~serial_unit_enable_bit) begin
      busy_ff    <= 1'b0;
      bit_cnt_ff <= CNT_ZERO;
    end else if (start) begin
      busy_ff    <= 1'b1;
      bit_cnt_ff <= CNT_ZERO;
    end else if (done_pulse) begin
      busy_ff    <= 1'b0;
      bit_cnt_ff <= CNT_ZERO;
    end else if (busy_ff & sample_edge) begin
      bit_cnt_ff <= bit_cnt_ff + CNT_ONE;
    end
  end

  // Shift register: loads the transmit byte, takes input on sample edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_ff <= BYTE_ZERO;
    end else if (~serial_unit_enable_bit) begin
      shift_ff <= BYTE_ZERO;
    end else if (start) begin
      shift_ff <= transmit_mode_bit ? (wr_now ? wbyte : transmit_buffer_ff) : BYTE_ZERO;
    end else if (busy_ff & sample_edge) begin
      shift_ff <= bit_order_bit ? {sin_s, shift_ff[BYTE_W-1:1]}
                                : {shift_ff[BYTE_W-2:0], sin_s};
    end
  end

  // A mode write that disables or leaves transmit clears the latch at its own edge,
  // otherwise the last sent bit would show on the idle output for one cycle
  logic mode_off_wr;
  assign mode_off_wr = wr_now & hit & (wb_adr_i == OFS_MODE) &
                       ~(wbyte[MODE_ENABLE] & wbyte[MODE_TXMODE]);

  // Output latch: cleared while disabled; phase 1 presents the first bit at start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_latch_ff <= 1'b0;
    end else if (~serial_unit_enable_bit | ~transmit_mode_bit | mode_off_wr) begin
      out_latch_ff <= 1'b0;
    end else if (start & data_phase_bit) begin
      out_latch_ff <= lead_bit(wbyte, bit_order_bit);
    end else if (busy_ff & drive_edge & ~(data_phase_bit & last_sample)) begin
      out_latch_ff <= lead_bit(shift_ff, bit_order_bit);
    end
  end

  // Idle selection is purely combinational so a mode write shows at once
  always_comb begin
    if (serial_unit_enable_bit) begin
      serial_data_out = transmit_mode_bit & out_latch_ff;
    end else if (~transmit_mode_bit) begin
      serial_data_out = 1'b0;
    end else if (~data_phase_bit) begin
      serial_data_out = out_latch_ff;
    end else begin
      serial_data_out = lead_bit(transmit_buffer_ff, bit_order_bit);
    end
  end

  // Pin drive: direction 0 drives; a set port latch forces the pin high
  assign data_pin_oe = ~port_direction_bit;
  assign data_pin_o  = serial_data_out | port_latch_bit;

  // Sticky flags: hardware set wins over a write-one clear in the same cycle
  logic [BYTE_W-1:0] irq_set;
  logic [BYTE_W-1:0] irq_clr;
  always_comb begin
    irq_set           = BYTE_ZERO;
    irq_set[IRQ_DONE] = done_pulse;
    irq_clr           = (wr_now & hit & (wb_adr_i == OFS_IRQST)) ? wbyte : BYTE_ZERO;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status_ff <= BYTE_ZERO;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
    end
  end

  // Level interrupt while any unmasked flag is set
  assign irq = |(irq_status_ff & irq_mask_ff);

  // Pin readback is unused by this unit; kept as a documented input
  logic unused_pin;
  assign unused_pin = data_pin_i;

endmodule
`default_nettype wire

// file: sois_props.sv
// Checker: port assertions for the serial output idle-select block
`default_nettype none
module sois_props (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         rst,
  // Bus
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [sois_pkg::ADDR_W-1:0]  wb_adr_i,
  input wire logic [3:0]                   wb_sel_i,
  input wire logic [sois_pkg::DATA_W-1:0]  wb_dat_i,
  input wire logic                         wb_ack_o,
  // Outputs
  input wire logic                         data_pin_o,
  input wire logic                         data_pin_oe,
  input wire logic                         serial_data_out
);
  import sois_pkg::*;
  logic [7:0] mode_ff;
  logic [7:0] txb_ff;
  logic [1:0] port_ff;
  logic       wr;
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  // Shadow of the control bits; writes land at the ack edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= MODE_RST;
      txb_ff  <= BYTE_ZERO;
      port_ff <= PORT_RST;
    end else if (wr) begin
      if (wb_adr_i == OFS_MODE) mode_ff <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_TXBUF) txb_ff <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_PORT) port_ff <= wb_dat_i[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Idle checks only hold while disabled; a live frame owns the output
  a_idle_low: assert property (!mode_ff[7] && !mode_ff[6] |-> !serial_data_out)
    else $error("idle output not low");
  a_idle_latch: assert property (!mode_ff[7] && mode_ff[6] && !mode_ff[3] |-> !serial_data_out)
    else $error("idle latch not low");
  a_idle_msb: assert property (!mode_ff[7] && mode_ff[6] && mode_ff[3] && !mode_ff[4]
    |-> serial_data_out == txb_ff[7]) else $error("idle msb wrong");
  a_idle_lsb: assert property (!mode_ff[7] && mode_ff[6] && mode_ff[3] && mode_ff[4]
    |-> serial_data_out == txb_ff[0]) else $error("idle lsb wrong");
  a_pin_level: assert property (data_pin_o == (serial_data_out | port_ff[1]))
    else $error("pin level wrong");
  a_pin_dir: assert property (data_pin_oe == !port_ff[0]) else $error("pin dir wrong");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
endmodule
bind sois_top sois_props i_props (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .data_pin_o(data_pin_o),
  .data_pin_oe(data_pin_oe), .serial_data_out(serial_data_out));
`default_nettype wire

// file: sois_peer.sv
// Partner model: peripheral IC clocking one 8-bit frame on request
`default_nettype none
module sois_peer (
  // Control from bench
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  // Link
  input  wire logic       sdo,
  output logic            sclk,
  output logic            sdi,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock idles high between frames; it never runs free
  initial begin
    sclk = 1'b1;
    sdi = 1'b0;
    rx_byte = 8'h00;
  end
  // Data changes on the leading edge, sampled on the trailing edge
  always @(posedge go) begin
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = tx_byte[i];
      #62.5 sclk = 1'b1;
      rx_byte = {rx_byte[6:0], sdo};
      #62.5;
    end
    sdi = ~sdi; // Line is driven to the inverse of the last bit so it shows no stale value
  end
endmodule
`default_nettype wire

// file: sois_top_tb.sv
// Testbench for the serial output idle-select block
`default_nettype none
module sois_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sois_pkg::*;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0;
  logic        sclk, sdi, irq, ack, sdo, pin, oe, e;
  logic [4:0]  adr = 0;
  logic [31:0] dat = 0, rdat;
  logic [7:0]  rx, b;
  logic [15:0] lf = 16'h7279;
  int          n_errors = 0, samples_checked = 0;
  logic [31:0] q[$];
  sois_top i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_clk_in(sclk), .serial_data_in(sdi), .data_pin_i(1'b0), .data_pin_o(pin),
    .data_pin_oe(oe), .serial_data_out(sdo), .irq(irq));
  sois_peer i_peer (.go(go), .tx_byte(lf[15:8]), .sdo(pin), .sclk(sclk), .sdi(sdi),
    .rx_byte(rx));
  always #4 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    samples_checked++;
    if (g !== ex) begin
      n_errors++;
      $display("Error %s exp %h got %h", nm, ex, g);
    end
  endtask
  // One classic cycle; waits on ack, never on a fixed count
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 1, 0);
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] ex);
    q.push_back(ex);
    wb(0, a, 0);
  endtask
  task automatic test_done;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Read data is matched in issue order at the ack edge
  always @(posedge clk) if (ack === 1'b1 && !we) chk("rdat", q.pop_front(), rdat);
  // Watchdog well past the expected run length
  initial begin
    #200us;
    n_errors++;
    test_done;
  end
  initial begin
    int n;
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("sdo", 0, sdo);
    rd(OFS_MODE, 0);
    rd(OFS_PORT, 1);
    rd(5'h1C, 0);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      b = lf[7:0];
      wb(1, OFS_TXBUF, b);
      wb(1, OFS_MODE, {1'b0, i[2], 1'b0, i[0], i[1], 3'b000});
      e = i[2] & i[1] & (i[0] ? b[0] : b[7]);
      chk("sdo", e, sdo);
    end
    for (int p = 3; p >= 0; p--) begin
      wb(1, OFS_PORT, p);
      chk("oe", !p[0], oe);
      chk("pin", e | p[1], pin);
    end
    wb(1, OFS_IRQMK, 4);
    wb(1, OFS_MODE, 8'hC0);
    lf = lfsr(lf);
    b = lf[7:0];
    wb(1, OFS_TXBUF, b);
    go <= 1;
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin @(posedge clk); n++; end
    go <= 0;
    chk("irq", 1, irq);
    rd(OFS_IRQST, 4);
    rd(OFS_MODE, 8'hC0);
    rd(OFS_SHIFT, lf[15:8]);
    chk("rx", b, rx);
    wb(1, OFS_IRQMK, 0);
    chk("irq", 0, irq);
    wb(1, OFS_IRQMK, 4);
    chk("irq", 1, irq);
    wb(1, OFS_IRQST, 4);
    chk("irq", 0, irq);
    rd(OFS_IRQST, 0);
    wb(1, OFS_MODE, 8'h40);
    chk("sdo", 0, sdo);
    wb(1, OFS_MODE, 0);
    chk("sdo", 0, sdo);
    test_done;
  end
endmodule
`default_nettype wire
